// [src/clock_request_control.sv]
// Clock request line control with APB register access and power-up sequencing
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module clock_request_control
   import clock_request_pkg::*;
#(
   parameter logic HAS_PCIE_INTERFACE = 1'b1,
   parameter int POWER_DELAY_CYCLES = POWER_TO_REQUEST_CYCLES
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Card pins
   input wire logic i_fundamental_reset_n,
   input wire logic i_ref_clock_pos,
   input wire logic i_clock_request_n,
   output logic o_clock_request_n,
   output logic o_clock_request_oe,
   // Link layer state, same clock domain
   input wire logic i_link_in_l1_idle,
   input wire logic i_link_exit_request,
   input wire logic i_rx_idle_break,
   input wire logic i_tx_idle_break,
   // Status
   output logic o_ref_clock_active,
   output logic o_link_control_aspm_l0s,
   output logic o_link_control_aspm_l1
);
   logic fundamental_reset_n_sync_n;
   logic ref_sync;
   logic line_sync_n;
   logic ref_active;
   logic [LINK_CONTROL_WIDTH-1:0] link_control_reg;
   logic fund_reset_prev_reg;
   logic [31:0] power_cnt_reg;
   logic power_valid_reg;
   request_state_e state_reg;
   request_state_e state_next;
   logic dyn_enable;
   logic want_clock;
   logic drive_low;
   logic apb_write;
   logic apb_read;
   logic [31:0] read_data;

   // Pin inputs pass two flops before any logic looks at them
   sync_two_flop u_fundamental_reset_n_sync
   (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_async(i_fundamental_reset_n),
      .o_sync(fundamental_reset_n_sync_n)
   );

   sync_two_flop u_ref_sync
   (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_async(i_ref_clock_pos),
      .o_sync(ref_sync)
   );

   sync_two_flop u_line_sync
   (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_async(i_clock_request_n),
      .o_sync(line_sync_n)
   );

   // Purely informational; no decision depends on the clock running
   ref_clock_monitor u_ref_monitor
   (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_ref_sync(ref_sync),
      .o_active(ref_active)
   );

   assign dyn_enable = link_control_reg[DYN_CLOCK_ENABLE_BIT];
   assign apb_write = i_psel && i_penable && i_pwrite;
   assign apb_read = i_psel && !i_pwrite;

   // Power-valid count; the request is already low from reset, so the bound is met with margin
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         power_cnt_reg <= '0;
         power_valid_reg <= 1'b0;
      end
      else if (power_cnt_reg < 32'(POWER_DELAY_CYCLES))
      begin
         power_cnt_reg <= power_cnt_reg + 32'h0000_0001;
      end
      else
      begin
         power_valid_reg <= 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         fund_reset_prev_reg <= 1'b0;
      else
         fund_reset_prev_reg <= fundamental_reset_n_sync_n;
   end

   // Defaults restored at power-up and on every warm reset
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         link_control_reg <= LINK_CONTROL_RESET;
      end
      else if (!fundamental_reset_n_sync_n)
      begin
         link_control_reg <= LINK_CONTROL_RESET;
      end
      else if (apb_write && i_paddr == LINK_CONTROL_SETTINGS_ADDR)
      begin
         link_control_reg <= i_pwdata[LINK_CONTROL_WIDTH-1:0] & LINK_CONTROL_WRITE_MASK;
      end
   end

   // Link wants the clock whenever it is not resting in L1.Idle
   assign want_clock = i_link_exit_request || i_rx_idle_break || i_tx_idle_break || !i_link_in_l1_idle;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_ASSERTED:
         begin
            // Release only with enable, in L1.Idle, and out of reset
            if (dyn_enable && !want_clock && fundamental_reset_n_sync_n && power_valid_reg)
               state_next = ST_RELEASED;
         end
         ST_RELEASED:
         begin
            // No dependence on reference clock edges to wake
            if (!dyn_enable || want_clock || !fundamental_reset_n_sync_n)
               state_next = ST_WAKING;
         end
         ST_WAKING:
         begin
            state_next = ST_ASSERTED;
         end
         default:
         begin
            state_next = ST_ASSERTED;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         state_reg <= ST_ASSERTED;
      else
         state_reg <= state_next;
   end

   // Immediate re-assertion on wake causes; no wait for the state update
   assign drive_low = (state_reg != ST_RELEASED) || !dyn_enable || want_clock || !fundamental_reset_n_sync_n;

   // Open drain: output data stays low, enable says when to sink
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_clock_request_n <= 1'b0;
         o_clock_request_oe <= HAS_PCIE_INTERFACE;
      end
      else
      begin
         o_clock_request_n <= 1'b0;
         o_clock_request_oe <= HAS_PCIE_INTERFACE && drive_low;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_ref_clock_active <= 1'b0;
         o_link_control_aspm_l0s <= 1'b1;
         o_link_control_aspm_l1 <= 1'b1;
      end
      else
      begin
         o_ref_clock_active <= ref_active;
         o_link_control_aspm_l0s <= link_control_reg[ASPM_L0S_BIT];
         o_link_control_aspm_l1 <= link_control_reg[ASPM_L1_BIT];
      end
   end

   always_comb
   begin
      read_data = '0;
      case (i_paddr)
         LINK_CONTROL_SETTINGS_ADDR:
            read_data = zero_extend16(link_control_reg);
         LINK_CAPABILITIES_ADDR:
            read_data = LINK_CAPABILITIES_VALUE;
         LINK_STATUS_ADDR:
         begin
            read_data[STAT_REQUEST_BIT] = !line_sync_n;
            read_data[STAT_REF_ACTIVE_BIT] = ref_active;
            read_data[STAT_STATE_LSB +: 2] = state_reg;
         end
         default:
            read_data = '0;
      endcase
   end

   // Zero-wait APB: pready rises in the setup cycle's following edge
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_prdata <= '0;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pready <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && i_paddr != LINK_CONTROL_SETTINGS_ADDR
            && i_paddr != LINK_CAPABILITIES_ADDR && i_paddr != LINK_STATUS_ADDR;
         if (apb_read && !i_penable)
            o_prdata <= read_data;
      end
   end
endmodule

// [src/clock_request_pkg.sv]
// Package with register map, field positions and timing constants for clock request control
package clock_request_pkg;
   // Register byte addresses
   localparam logic [11:0] LINK_CONTROL_SETTINGS_ADDR = 12'h010;
   localparam logic [11:0] LINK_CAPABILITIES_ADDR = 12'h0c4;
   localparam logic [11:0] LINK_STATUS_ADDR = 12'h020;
   // Link control field positions
   localparam int ASPM_L0S_BIT = 0;
   localparam int ASPM_L1_BIT = 1;
   localparam int DYN_CLOCK_ENABLE_BIT = 8;
   localparam int LINK_CONTROL_WIDTH = 16;
   localparam logic [15:0] LINK_CONTROL_RESET = 16'h0103;
   localparam logic [15:0] LINK_CONTROL_WRITE_MASK = 16'h0103;
   // Link capabilities field positions
   localparam int CAP_ASPM_LSB = 10;
   localparam int CAP_CLOCK_PM_BIT = 18;
   localparam logic [31:0] LINK_CAPABILITIES_VALUE = 32'h00040c00;
   // Link status field positions
   localparam int STAT_REQUEST_BIT = 0;
   localparam int STAT_REF_ACTIVE_BIT = 1;
   localparam int STAT_STATE_LSB = 4;
   // Timing
   localparam int CLOCK_MHZ = 40;
   localparam int POWER_TO_REQUEST_DELAY_US = 100;
   localparam int POWER_TO_REQUEST_CYCLES = POWER_TO_REQUEST_DELAY_US * CLOCK_MHZ;
   localparam int REQUEST_TO_CLOCK_ACTIVE_DELAY_NS = 400;
   localparam int REF_ACTIVITY_WINDOW_CYCLES = (REQUEST_TO_CLOCK_ACTIVE_DELAY_NS * CLOCK_MHZ + 999) / 1000;
   localparam int ACT_CNT_WIDTH = 5;
   // Request controller states
   typedef enum logic [1:0]
   {
      ST_ASSERTED = 2'b00,
      ST_RELEASED = 2'b01,
      ST_WAKING = 2'b10
   } request_state_e;
   // Zero extension of a 16-bit register into the bus slave read data
   function automatic logic [31:0] zero_extend16(input logic [15:0] value);
      zero_extend16 = {16'h0000, value};
   endfunction
endpackage

// [src/ref_clock_monitor.sv]
// Reference clock activity detector working from sampled clock edges
`timescale 1ns/1ps
module ref_clock_monitor
   import clock_request_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Synchronised reference clock level
   input wire logic i_ref_sync,
   // Activity indication
   output logic o_active
);
   logic prev_reg;
   logic [ACT_CNT_WIDTH-1:0] idle_cnt_reg;

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         prev_reg <= 1'b0;
      else
         prev_reg <= i_ref_sync;
   end

   // Any edge restarts the window; a parked pair shows no edges at all
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         idle_cnt_reg <= '0;
         o_active <= 1'b0;
      end
      else if (prev_reg != i_ref_sync)
      begin
         idle_cnt_reg <= ACT_CNT_WIDTH'(REF_ACTIVITY_WINDOW_CYCLES);
         o_active <= 1'b1;
      end
      else if (idle_cnt_reg != '0)
      begin
         idle_cnt_reg <= idle_cnt_reg - 1'b1;
      end
      else
      begin
         o_active <= 1'b0;
      end
   end
endmodule

// [src/sync_two_flop.sv]
// Two-flop synchroniser for single-bit levels from outside the clock domain
`timescale 1ns/1ps
module sync_two_flop
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Level in and out
   input wire logic i_async,
   output logic o_sync
);
   logic stage1_reg;

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         stage1_reg <= 1'b0;
         o_sync <= 1'b0;
      end
      else
      begin
         stage1_reg <= i_async;
         o_sync <= stage1_reg;
      end
   end
endmodule

// [verif/clock_request_sva.sv]
// Concurrent checks on the clock request control ports
`timescale 1ns/1ps
module clock_request_sva
#(
   parameter logic HAS_PCIE_INTERFACE = 1'b1
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Bus handshake
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // Pins and link state
   input wire logic i_fundamental_reset_n,
   input wire logic o_clock_request_n,
   input wire logic o_clock_request_oe,
   input wire logic i_link_in_l1_idle,
   input wire logic i_link_exit_request,
   input wire logic i_rx_idle_break,
   input wire logic i_tx_idle_break,
   input wire logic o_link_control_aspm_l0s,
   input wire logic o_link_control_aspm_l1
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   sequence s_setup;
      i_psel && !i_penable;
   endsequence
   sequence s_released;
      !o_clock_request_oe;
   endsequence
   chk_apb_answer: assert property (s_setup |=> o_pready)
      else $error("no ready after setup");
   chk_ready_pulse: assert property (o_pready |=> !o_pready)
      else $error("ready longer than one cycle");
   chk_error_pairs: assert property (o_pslverr |-> o_pready)
      else $error("error without ready");
   chk_reset_request: assert property ($rose(i_rst_n) |-> o_clock_request_oe == HAS_PCIE_INTERFACE)
      else $error("request not asserted out of reset");
   chk_aspm_default: assert property ($rose(i_rst_n) |-> o_link_control_aspm_l0s && o_link_control_aspm_l1)
      else $error("power states not enabled out of reset");
   chk_fundamental_reset_n_hold: assert property (!i_fundamental_reset_n [*5] |-> o_clock_request_oe)
      else $error("request released under fundamental reset");
   chk_l1_release: assert property ($fell(o_clock_request_oe) |-> $past(i_link_in_l1_idle, 2))
      else $error("request released outside idle state");
   chk_rx_wake: assert property (s_released ##0 i_rx_idle_break |=> o_clock_request_oe)
      else $error("idle break did not assert request");
   chk_exit_wake: assert property (s_released ##0 (i_link_exit_request || i_tx_idle_break) |=> o_clock_request_oe)
      else $error("exit did not assert request");
   chk_line_data: assert property (o_clock_request_oe |-> !o_clock_request_n)
      else $error("line driven high");
endmodule

// [verif/host_clock_model.sv]
// Host reference clock source and reset model facing the card
`timescale 1ns/1ps
module host_clock_model
#(
   parameter int SETUP_NS = 2000
)
(
   // Shared line and bench controls
   input wire logic i_clock_request_line_n,
   input wire logic i_keep_running,
   input wire logic i_hold_reset,
   // Card pins
   output logic o_ref_clock_pos,
   output logic o_fundamental_reset_n
);
   time active_since;
   logic running;
   initial
   begin
      o_ref_clock_pos = 1'b0; // Parked before power
      o_fundamental_reset_n = 1'b0;
      running = 1'b0;
      active_since = 0;
      #37;
      forever
      begin
         #100;
         // Unrelated phase; start lags the request by under 400 ns
         if (i_clock_request_line_n === 1'b0 || i_keep_running)
         begin
            if (!running)
               active_since = $time;
            running = 1'b1;
            o_ref_clock_pos = ~o_ref_clock_pos;
         end
         else
         begin
            running = 1'b0;
            o_ref_clock_pos = 1'b0;
         end
         if (i_hold_reset)
            o_fundamental_reset_n = 1'b0;
         else if (running && $time - active_since >= SETUP_NS)
            o_fundamental_reset_n = 1'b1;
      end
   end
endmodule

// [verif/testbench.sv]
// Self-checking bench for the clock request control block
`timescale 1ns/1ps
module testbench
   import clock_request_pkg::*;
;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, req_n, req_oe, line_n, ref_pos, fundamental_reset_n_n, ref_active, aspm_l0s, aspm_l1;
   logic l1_idle = 1'b0, keep_running = 1'b0, hold_reset = 1'b0;
   logic [2:0] wake = 3'b000;
   int fail_count = 0, checks = 0, cycles = 0, seed = 32'h3e2a, link_model;
   // Pull-up on the shared line
   assign line_n = (req_oe === 1'b1) ? req_n : 1'b1;
   always #12.5 clock = ~clock;
   clock_request_control #(.HAS_PCIE_INTERFACE(1'b1), .POWER_DELAY_CYCLES(20)) u_clock_request_control
   (
      .i_clock(clock),
      .i_rst_n(rst_n),
      .i_psel(psel),
      .i_penable(penable),
      .i_pwrite(pwrite),
      .i_paddr(paddr),
      .i_pwdata(pwdata),
      .o_prdata(prdata),
      .o_pready(pready),
      .o_pslverr(pslverr),
      .i_fundamental_reset_n(fundamental_reset_n_n),
      .i_ref_clock_pos(ref_pos),
      .i_clock_request_n(line_n),
      .o_clock_request_n(req_n),
      .o_clock_request_oe(req_oe),
      .i_link_in_l1_idle(l1_idle),
      .i_link_exit_request(wake[2]),
      .i_rx_idle_break(wake[0]),
      .i_tx_idle_break(wake[1]),
      .o_ref_clock_active(ref_active),
      .o_link_control_aspm_l0s(aspm_l0s),
      .o_link_control_aspm_l1(aspm_l1)
   );
   host_clock_model u_host_clock_model
   (
      .i_clock_request_line_n(line_n),
      .i_keep_running(keep_running),
      .i_hold_reset(hold_reset),
      .o_ref_clock_pos(ref_pos),
      .o_fundamental_reset_n(fundamental_reset_n_n)
   );
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
         @(posedge clock);
      while (pready !== 1'b1 && n++ < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wait_oe(input logic v);
      int n;
      n = 0;
      while (req_oe !== v && n < 400)
      begin
         @(posedge clock);
         n++;
      end
      chk("request oe", req_oe, v);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         fail_count++;
         finish_test();
      end
   end
   initial
   begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      l1_idle <= 1'b1;
      @(posedge clock);
      chk("oe after reset", req_oe, 1'b1);
      chk("aspm", {aspm_l1, aspm_l0s}, 2'b11);
      link_model = 32'h0103;
      apb(1'b0, LINK_CONTROL_SETTINGS_ADDR, 32'h0);
      chk("control", rd, link_model);
      apb(1'b0, LINK_CAPABILITIES_ADDR, 32'h0);
      chk("clock pm cap", rd[CAP_CLOCK_PM_BIT], 1'b1);
      apb(1'b1, 12'h100, 32'hffff_ffff);
      chk("unmapped error", err, 1'b1);
      repeat (30) @(posedge clock);
      chk("held under fundamental_reset_n", req_oe, 1'b1);
      wait_oe(1'b0);
      $display("test power-up done");
      for (int k = 0; k < 3; k++)
      begin
         wake <= 3'b001 << k;
         repeat (2) @(posedge clock);
         chk("wake request", req_oe, 1'b1);
         wake <= 3'b000;
         wait_oe(1'b0);
      end
      keep_running <= 1'b1;
      repeat (30) @(posedge clock);
      chk("ref active", ref_active, 1'b1);
      chk("still released", req_oe, 1'b0);
      keep_running <= 1'b0;
      $display("test wake done");
      link_model = 32'h0003;
      apb(1'b1, LINK_CONTROL_SETTINGS_ADDR, link_model);
      // Output is registered one edge after the write lands
      @(posedge clock);
      chk("disable reasserts", req_oe, 1'b1);
      repeat (40) @(posedge clock);
      chk("disabled held", req_oe, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
         link_model = $random(seed);
         apb(1'b1, LINK_CONTROL_SETTINGS_ADDR, link_model);
         link_model = link_model & 32'h0103;
         apb(1'b0, LINK_CONTROL_SETTINGS_ADDR, 32'h0);
         chk("control readback", rd, link_model);
         chk("aspm copy", {aspm_l1, aspm_l0s}, link_model[1:0]);
      end
      $display("test control done");
      // Released first, so only the fundamental reset can pull the request back
      apb(1'b1, LINK_CONTROL_SETTINGS_ADDR, 32'h0103);
      wait_oe(1'b0);
      hold_reset <= 1'b1;
      repeat (10) @(posedge clock);
      chk("fundamental_reset_n forces", req_oe, 1'b1);
      apb(1'b0, LINK_CONTROL_SETTINGS_ADDR, 32'h0);
      chk("warm default", rd, 32'h0103);
      hold_reset <= 1'b0;
      wait_oe(1'b0);
      $display("test warm reset done");
      finish_test();
   end
endmodule
bind clock_request_control clock_request_sva #(.HAS_PCIE_INTERFACE(HAS_PCIE_INTERFACE)) u_clock_request_sva
(
   .i_clock(i_clock),
   .i_rst_n(i_rst_n),
   .i_psel(i_psel),
   .i_penable(i_penable),
   .o_pready(o_pready),
   .o_pslverr(o_pslverr),
   .i_fundamental_reset_n(i_fundamental_reset_n),
   .o_clock_request_n(o_clock_request_n),
   .o_clock_request_oe(o_clock_request_oe),
   .i_link_in_l1_idle(i_link_in_l1_idle),
   .i_link_exit_request(i_link_exit_request),
   .i_rx_idle_break(i_rx_idle_break),
   .i_tx_idle_break(i_tx_idle_break),
   .o_link_control_aspm_l0s(o_link_control_aspm_l0s),
   .o_link_control_aspm_l1(o_link_control_aspm_l1)
);
